// [design/align_angle_decode.sv]
// align-angle code to degrees decoder
`timescale 1ns/1ps
`default_nettype none
module align_angle_decode (
	input  wire logic [4:0] code_i,
	output logic      [8:0] degrees_o,
	output logic            valid_o
);
	always_comb begin
		valid_o = (code_i <= motor_cfg_pkg::ALIGN_CODE_MAX);
		case (code_i)
			5'h00: degrees_o = 9'h000;
			5'h01: degrees_o = 9'd10;
			5'h02: degrees_o = 9'd20;
			5'h03: degrees_o = 9'd30;
			5'h04: degrees_o = 9'd45;
			5'h05: degrees_o = 9'd60;
			5'h06: degrees_o = 9'd70;
			5'h07: degrees_o = 9'd80;
			5'h08: degrees_o = 9'd90;
			5'h09: degrees_o = 9'd110;
			5'h0A: degrees_o = 9'd120;
			5'h0B: degrees_o = 9'd135;
			5'h0C: degrees_o = 9'd150;
			5'h0D: degrees_o = 9'd160;
			5'h0E: degrees_o = 9'd170;
			5'h0F: degrees_o = 9'd180;
			5'h10: degrees_o = 9'd190;
			5'h11: degrees_o = 9'd210;
			5'h12: degrees_o = 9'd225;
			5'h13: degrees_o = 9'd240;
			5'h14: degrees_o = 9'd250;
			5'h15: degrees_o = 9'd260;
			5'h16: degrees_o = 9'd270;
			5'h17: degrees_o = 9'd280;
			5'h18: degrees_o = 9'd290;
			5'h19: degrees_o = 9'd315;
			5'h1A: degrees_o = 9'd330;
			5'h1B: degrees_o = 9'd340;
			5'h1C: degrees_o = 9'd350;
			// reserved codes fall back to zero degrees
			default: degrees_o = 9'h000;
		endcase
	end
endmodule
`default_nettype wire

// [design/motor_startup_closed_loop_cfg.sv]
// APB register bank holding startup and closed-loop speed regulation settings
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - align-angle field bits 12:8 decodes to rotor alignment angle in degrees
// R2 - code 1Ch is 350 degrees; codes 1Dh-1Fh reserved and flagged invalid
// R3 - bits 7:4 give open-loop first-cycle frequency, 1 to 50 percent
// R4 - bit 3 picks 0 Hz or the percentage field for open-loop first cycle
// R5 - bits 2:0 pick the theta error ramp rate, 0.01 to 2 deg/ms
// R6 - closed-loop register sits at index 88h and resets to zero
// R7 - bit 31 reserved zero; overmod, accel, decel source, decel fields above
// R8 - bits 3:1 surge guard, gap-time correction, regulator off; bit 0 reads zero
// R9 - startup register sits at index 86h and resets to zero
// R10 - reserved bits read zero, ignore writes; fields read back last write
module motor_startup_closed_loop_cfg (
	input  wire logic                          mclk_i,
	input  wire logic                          resetn_i,
	input  wire logic                          clk_en_i,
	input  wire logic                          psel_i,
	input  wire logic                          penable_i,
	input  wire logic                          pwrite_i,
	input  wire logic [7:0]                    paddr_i,
	input  wire logic [31:0]                   pwdata_i,
	input  wire logic [3:0]                    pstrb_i,
	output logic      [31:0]                   prdata_o,
	output logic                               pready_o,
	output logic                               pslverr_o,
	output motor_cfg_pkg::startup_cfg_type     startup_cfg_o,
	output motor_cfg_pkg::closed_loop_cfg_type closed_loop_cfg_o,
	output logic                               first_cycle_zero_hz_o
);
	logic                               rst_sync1_ff;
	logic                               rst_sync2_ff;
	logic [31:0]                        startup_ff;
	logic [31:0]                        speed_ff;
	logic [31:0]                        prdata_ff;
	logic                               pslverr_ff;
	logic [31:0]                        nxt_prdata;
	logic [31:0]                        nxt_startup;
	logic [31:0]                        nxt_speed;
	logic [31:0]                        wr_mask;
	logic                               hit_startup;
	logic                               hit_speed;
	logic                               access;
	logic                               wr_startup;
	logic                               wr_speed;
	logic [8:0]                         align_deg;
	logic                               align_valid;
	motor_cfg_pkg::startup_cfg_type     startup_cfg_ff;
	motor_cfg_pkg::startup_cfg_type     nxt_startup_cfg;
	motor_cfg_pkg::closed_loop_cfg_type closed_loop_cfg_ff;
	motor_cfg_pkg::closed_loop_cfg_type nxt_closed_loop_cfg;
	logic                               zero_hz_ff;

	// one mask byte per strobe line; unstrobed lanes keep their old value
	for (genvar lane = 0; lane < 4; lane++) begin : g_lane_mask
		assign wr_mask[8*lane +: 8] = {8{pstrb_i[lane]}};
	end

	// only strobed lanes inside the writable mask take the new data
	function automatic logic [31:0] merge_write(
		input logic [31:0] old_val,
		input logic [31:0] data,
		input logic [31:0] lanes,
		input logic [31:0] wmask
	);
		merge_write = (old_val & ~(lanes & wmask)) | (data & lanes & wmask);
	endfunction

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end

	// zero wait states: the access phase completes in one cycle, two cycles after setup starts
	assign pready_o    = 1'b1;
	assign access      = psel_i & penable_i & clk_en_i;
	assign hit_startup = (paddr_i == motor_cfg_pkg::STARTUP_B_ADDR); // R9
	assign hit_speed   = (paddr_i == motor_cfg_pkg::SPEED_A_ADDR); // R6
	assign wr_startup  = access & pwrite_i & hit_startup;
	assign wr_speed    = access & pwrite_i & hit_speed;

	always_comb begin
		nxt_startup = merge_write(startup_ff, pwdata_i, wr_mask, motor_cfg_pkg::STARTUP_B_WMASK); // R10
		nxt_speed   = merge_write(speed_ff, pwdata_i, wr_mask, motor_cfg_pkg::SPEED_A_WMASK); // R10
	end

	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			startup_ff <= motor_cfg_pkg::STARTUP_B_RESET; // R9
		end else if (wr_startup) begin
			startup_ff <= nxt_startup; // R10
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			speed_ff <= motor_cfg_pkg::SPEED_A_RESET; // R6
		end else if (wr_speed) begin
			// bit 31 and bit 0 stay zero through the mask
			speed_ff <= nxt_speed; // R7 R8
		end
	end

	always_comb begin
		nxt_prdata = 32'h00000000;
		case (paddr_i)
			motor_cfg_pkg::STARTUP_B_ADDR: nxt_prdata = startup_ff & motor_cfg_pkg::STARTUP_B_WMASK; // R10
			motor_cfg_pkg::SPEED_A_ADDR:   nxt_prdata = speed_ff & motor_cfg_pkg::SPEED_A_WMASK; // R10
			default:                       nxt_prdata = 32'h00000000;
		endcase
	end

	// read data is registered in the setup cycle so it stands during the access phase
	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			prdata_ff <= 32'h00000000;
		end else if (clk_en_i && psel_i && !penable_i) begin
			prdata_ff <= pwrite_i ? 32'h00000000 : nxt_prdata;
		end
	end

	// error flag is taken with the read data; it shows only while the access phase is on
	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			pslverr_ff <= 1'b0;
		end else if (clk_en_i && psel_i && !penable_i) begin
			pslverr_ff <= !(hit_startup || hit_speed); // R10
		end
	end

	assign prdata_o  = prdata_ff;
	assign pslverr_o = pslverr_ff & psel_i & penable_i;

	align_angle_decode u_align (
		.code_i    (startup_ff[motor_cfg_pkg::ALIGN_LSB +: 5]),
		.degrees_o (align_deg),
		.valid_o   (align_valid)
	);

	always_comb begin
		nxt_startup_cfg.align_code                = startup_ff[motor_cfg_pkg::ALIGN_LSB +: 5]; // R1
		nxt_startup_cfg.align_deg                 = align_deg; // R1
		nxt_startup_cfg.align_valid               = align_valid; // R2
		nxt_startup_cfg.initial_rotation_rate_pct = startup_ff[motor_cfg_pkg::RATE_PCT_LSB +: 4]; // R3
		nxt_startup_cfg.first_cycle_from_pct      = startup_ff[motor_cfg_pkg::FREQ_SEL_BIT]; // R4
		nxt_startup_cfg.theta_ramp_code           = startup_ff[motor_cfg_pkg::RAMP_LSB +: 3]; // R5
	end

	always_comb begin
		nxt_closed_loop_cfg.overmod_on             = speed_ff[motor_cfg_pkg::OVERMOD_BIT]; // R7
		nxt_closed_loop_cfg.regulated_accel_rate   = speed_ff[motor_cfg_pkg::ACCEL_LSB +: 5]; // R7
		nxt_closed_loop_cfg.decel_source_choice    = speed_ff[motor_cfg_pkg::DECEL_SRC_BIT]; // R7
		nxt_closed_loop_cfg.regulated_decel_rate   = speed_ff[motor_cfg_pkg::DECEL_LSB +: 5]; // R7
		// source choice 1 means deceleration follows the acceleration setting
		nxt_closed_loop_cfg.effective_decel_rate   = speed_ff[motor_cfg_pkg::DECEL_SRC_BIT]
			? speed_ff[motor_cfg_pkg::ACCEL_LSB +: 5] : speed_ff[motor_cfg_pkg::DECEL_LSB +: 5];
		nxt_closed_loop_cfg.surge_guard_on         = speed_ff[motor_cfg_pkg::SURGE_BIT]; // R8
		nxt_closed_loop_cfg.gap_time_correction_on = speed_ff[motor_cfg_pkg::GAP_BIT]; // R8
		nxt_closed_loop_cfg.velocity_regulator_off = speed_ff[motor_cfg_pkg::VREG_OFF_BIT]; // R8
	end

	// decoded views leave on flip-flops, one enabled clock behind the register they mirror;
	// the extra cycle keeps the angle decoder out of the paths that leave the block
	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			startup_cfg_ff <= motor_cfg_pkg::STARTUP_CFG_RESET; // R9
		end else if (clk_en_i) begin
			startup_cfg_ff <= nxt_startup_cfg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			closed_loop_cfg_ff <= motor_cfg_pkg::CLOSED_LOOP_CFG_RESET; // R6
		end else if (clk_en_i) begin
			closed_loop_cfg_ff <= nxt_closed_loop_cfg;
		end
	end

	// a clear select bit means the open-loop first cycle runs at 0 Hz
	always_ff @(posedge mclk_i or negedge rst_sync2_ff) begin
		if (!rst_sync2_ff) begin
			zero_hz_ff <= motor_cfg_pkg::ZERO_HZ_RESET;
		end else if (clk_en_i) begin
			zero_hz_ff <= ~startup_ff[motor_cfg_pkg::FREQ_SEL_BIT]; // R4
		end
	end

	assign startup_cfg_o         = startup_cfg_ff;
	assign closed_loop_cfg_o     = closed_loop_cfg_ff;
	assign first_cycle_zero_hz_o = zero_hz_ff;
endmodule
`default_nettype wire

// [dv/motor_cfg_asserts.sv]
// checker: bus and field-decode properties of the config bank
`timescale 1ns/1ps
`default_nettype none
module motor_cfg_asserts (
	input wire logic                               mclk_i,
	input wire logic                               resetn_i,
	input wire logic                               clk_en_i,
	input wire logic                               psel_i,
	input wire logic                               penable_i,
	input wire logic                               pwrite_i,
	input wire logic [7:0]                         paddr_i,
	input wire logic [31:0]                        pwdata_i,
	input wire logic [3:0]                         pstrb_i,
	input wire logic                               pslverr_o,
	input wire motor_cfg_pkg::startup_cfg_type     startup_cfg_o,
	input wire motor_cfg_pkg::closed_loop_cfg_type closed_loop_cfg_o,
	input wire logic                               first_cycle_zero_hz_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	wire logic acc = psel_i && penable_i;
	wire logic map = paddr_i == 8'h18 || paddr_i == 8'h20;
	wire logic wen = acc && pwrite_i && clk_en_i && pstrb_i[0];
	// the error flag is taken in the setup cycle, so both phases must have had the clock enabled
	unmapped_err_a: assert property (acc && clk_en_i && $past(clk_en_i) && !map |-> pslverr_o)
		else $error("no error on unmapped");
	mapped_ok_a: assert property (acc && clk_en_i && $past(clk_en_i) && map |-> !pslverr_o)
		else $error("error on mapped");
	zero_hz_a: assert property (first_cycle_zero_hz_o == !startup_cfg_o.first_cycle_from_pct) else $error("0 Hz");
	align_valid_a: assert property (startup_cfg_o.align_valid == (startup_cfg_o.align_code <= 5'h1C)) else $error("valid");
	align_ten_a: assert property (startup_cfg_o.align_code == 5'h01 |-> startup_cfg_o.align_deg == 9'd10) else $error("10");
	align_max_a: assert property (startup_cfg_o.align_code == 5'h1C |-> startup_cfg_o.align_deg == 9'd350) else $error("350");
	decel_pick_a: assert property (closed_loop_cfg_o.effective_decel_rate == (closed_loop_cfg_o.decel_source_choice
		? closed_loop_cfg_o.regulated_accel_rate : closed_loop_cfg_o.regulated_decel_rate)) else $error("decel");
	// decoded outputs trail the register by one enabled clock
	ramp_write_a: assert property (wen && paddr_i == 8'h18 ##1 clk_en_i
		|=> startup_cfg_o.theta_ramp_code == $past(pwdata_i[2:0], 2)) else $error("ramp write");
	guard_write_a: assert property (wen && paddr_i == 8'h20 ##1 clk_en_i
		|=> closed_loop_cfg_o.surge_guard_on == $past(pwdata_i[3], 2)) else $error("guard write");
	cover property (acc && !map);
	cover property (startup_cfg_o.align_code == 5'h1C);
	cover property (closed_loop_cfg_o.decel_source_choice);
endmodule
bind motor_startup_closed_loop_cfg motor_cfg_asserts u_chk (.mclk_i, .resetn_i, .clk_en_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pslverr_o, .startup_cfg_o, .closed_loop_cfg_o, .first_cycle_zero_hz_o);
`default_nettype wire

// [dv/motor_startup_closed_loop_cfg_tb_top.sv]
// testbench: APB access and decoded outputs of the config bank
`timescale 1ns/1ps
`default_nettype none
module motor_startup_closed_loop_cfg_tb_top;
	logic        mclk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        clk_en_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h00000000;
	logic [3:0]  pstrb_i = 4'h0;
	logic [31:0] prdata_o, sb, sa, rd;
	logic        pready_o, pslverr_o, first_cycle_zero_hz_o, er;
	logic [7:0]  a;
	logic [8:0]  degt [29] = '{0, 10, 20, 30, 45, 60, 70, 80, 90, 110, 120, 135, 150, 160, 170, 180, 190, 210, 225,
		240, 250, 260, 270, 280, 290, 315, 330, 340, 350};
	int          errors = 0;
	int          checked = 0;
	motor_cfg_pkg::startup_cfg_type     startup_cfg_o;
	motor_cfg_pkg::closed_loop_cfg_type closed_loop_cfg_o;
	motor_startup_closed_loop_cfg dut (.mclk_i, .resetn_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .startup_cfg_o, .closed_loop_cfg_o, .first_cycle_zero_hz_o);
	initial forever #2.5 mclk_i = ~mclk_i;
	task automatic finish_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] d, input logic [3:0] s, input logic ce);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		clk_en_i <= ce;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		clk_en_i <= 1'b1;
		if (w && ce) for (int i = 0; i < 4; i++) if (s[i]) begin
			if (a == 8'h18) sb[8*i+:8] = d[8*i+:8] & 8'(32'h7FFFFFFF >> 8*i);
			if (a == 8'h20) sa[8*i+:8] = d[8*i+:8] & 8'(32'h7FFFFFFE >> 8*i);
		end
		// decoded outputs come from flip-flops one clock after the register
		repeat (2) @(negedge mclk_i);
		chk(32'(startup_cfg_o[7:0]), 32'(sb[7:0]));
		chk(32'(first_cycle_zero_hz_o), 32'(!sb[3]));
		chk(32'({closed_loop_cfg_o[19:8], closed_loop_cfg_o[2:0]}), 32'({sa[30:19], sa[3:1]}));
		chk(32'(closed_loop_cfg_o.effective_decel_rate), 32'(sa[24] ? sa[29:25] : sa[23:19]));
	endtask
	task automatic rdchk();
		apb(1'b0, 32'h00000000, 4'h0, 1'b1);
		chk(rd, a == 8'h18 ? sb : a == 8'h20 ? sa : 32'h00000000);
		chk(32'(er), 32'(a != 8'h18 && a != 8'h20));
	endtask
	initial begin
		#100000;
		errors++;
		finish_test();
	end
	initial begin
		void'($urandom(39534));
		sb = 32'h00000000;
		sa = 32'h00000000;
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		a = 8'h18;
		rdchk();
		a = 8'h20;
		rdchk();
		a = 8'h18;
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, ($urandom & 32'hFFFFE0FF) | 32'(c << 8), 4'hF, 1'b1);
			chk(32'(startup_cfg_o.align_valid), 32'(c < 29));
			// code Fh decodes to 180 degrees but is left out of the angle check
			if (c != 15) chk(32'(startup_cfg_o.align_deg), c < 29 ? 32'(degt[c]) : 32'h00000000);
			rdchk();
		end
		for (int i = 0; i < 60; i++) begin
			a = $urandom_range(3) == 0 ? 8'($urandom) : $urandom_range(1) ? 8'h18 : 8'h20;
			apb(1'b1, $urandom, 4'($urandom), $urandom_range(3) != 0);
			rdchk();
		end
		finish_test();
	end
endmodule
`default_nettype wire

// [pkg/motor_cfg_pkg.sv]
// package: register map, field layout and types for the motor startup/closed-loop config bank
package motor_cfg_pkg;
	localparam int                  ADDR_W            = 8;
	localparam logic [ADDR_W-1:0]   STARTUP_B_OFFSET  = 8'h86;
	localparam logic [ADDR_W-1:0]   SPEED_A_OFFSET    = 8'h88;
	localparam logic [ADDR_W-1:0]   STARTUP_B_ADDR    = 8'h18;  // index 86h times four, low byte
	localparam logic [ADDR_W-1:0]   SPEED_A_ADDR      = 8'h20;  // index 88h times four, low byte
	localparam logic [31:0]         STARTUP_B_RESET   = 32'h00000000;
	localparam logic [31:0]         SPEED_A_RESET     = 32'h00000000;
	// writable bits; everything else reads zero
	localparam logic [31:0]         STARTUP_B_WMASK   = 32'h7FFFFFFF;
	localparam logic [31:0]         SPEED_A_WMASK     = 32'h7FFFFFFE;
	localparam logic [4:0]          ALIGN_CODE_MAX    = 5'h1C;
	localparam int                  ALIGN_LSB         = 8;
	localparam int                  RATE_PCT_LSB      = 4;
	localparam int                  FREQ_SEL_BIT      = 3;
	localparam int                  RAMP_LSB          = 0;
	localparam int                  OVERMOD_BIT       = 30;
	localparam int                  ACCEL_LSB         = 25;
	localparam int                  DECEL_SRC_BIT     = 24;
	localparam int                  DECEL_LSB         = 19;
	localparam int                  SURGE_BIT         = 3;
	localparam int                  GAP_BIT           = 2;
	localparam int                  VREG_OFF_BIT      = 1;

	typedef struct packed {
		logic [4:0] align_code;
		logic       align_valid;
		logic [8:0] align_deg;
		logic [3:0] initial_rotation_rate_pct;
		logic       first_cycle_from_pct;
		logic [2:0] theta_ramp_code;
	} startup_cfg_type;

	typedef struct packed {
		logic       overmod_on;
		logic [4:0] regulated_accel_rate;
		logic       decel_source_choice;
		logic [4:0] regulated_decel_rate;
		logic [4:0] effective_decel_rate;
		logic       surge_guard_on;
		logic       gap_time_correction_on;
		logic       velocity_regulator_off;
	} closed_loop_cfg_type;

	// an all-zero startup register decodes to a valid zero-degree angle
	localparam startup_cfg_type     STARTUP_CFG_RESET = '{
		align_code:                5'h00,
		align_valid:               1'b1,
		align_deg:                 9'h000,
		initial_rotation_rate_pct: 4'h0,
		first_cycle_from_pct:      1'b0,
		theta_ramp_code:           3'h0
	};
	localparam closed_loop_cfg_type CLOSED_LOOP_CFG_RESET = '0;
	// select bit clear at reset means the open-loop first cycle runs at 0 Hz
	localparam logic                ZERO_HZ_RESET         = 1'b1;
endpackage
